// *** shared/ssdc_pkg.sv ***
// Shared constants, register map and types for the stepper and servo drive control block.
package ssdc_pkg;
  // Clock rate and derived tick counts.
  localparam int CLK_PERIOD_NS    = 8;
  localparam int TRAP_TICK_NS     = 1_000_000;
  localparam int TRAP_TICK_CYCLES = TRAP_TICK_NS / CLK_PERIOD_NS;
  localparam int LOOP_PERIOD_NS   = 10_000;
  localparam int LOOP_CYCLES      = LOOP_PERIOD_NS / CLK_PERIOD_NS;

  // Word indices of the registers; the byte address is four times the index.
  localparam int REG_MODE     = 0;
  localparam int REG_INNER    = 1;
  localparam int REG_NVEL     = 2;
  localparam int REG_DAMP     = 3;
  localparam int REG_OUTER    = 4;
  localparam int REG_FVEL     = 5;
  localparam int REG_TTIME    = 6;
  localparam int REG_IHOLD    = 7;
  localparam int REG_INPOS    = 8;
  localparam int REG_PEAK     = 9;
  localparam int REG_TLEVEL   = 10;
  localparam int REG_KP       = 11;
  localparam int REG_KI       = 12;
  localparam int REG_KPOS     = 13;
  localparam int REG_KF       = 14;
  localparam int REG_FFSW     = 15;
  localparam int REG_RUN      = 16;
  localparam int REG_HOLD     = 17;
  localparam int REG_SPP      = 18;
  localparam int REG_PEMAX    = 19;
  localparam int NCFG         = 20;
  localparam int REG_CTRL     = 20;
  localparam int REG_FAULT    = 21;
  localparam int REG_STATUS   = 22;
  localparam int REG_SLIPDIFF = 23;
  localparam int NREG         = 24;

  // Reset values: 50 units, 4000 units/s, 10000 ms, 5000 mA, 2000 mA, Kpos 0.9999 in Q16.
  localparam logic [31:0] CFG_RST [NCFG] = '{
    32'h0000_0000, 32'h0000_0032, 32'h0000_0FA0, 32'h0000_0000,
    32'h0000_0032, 32'h0000_0FA0, 32'h0000_2710, 32'h0000_0000,
    32'h0000_0001, 32'h0000_1388, 32'h0000_07D0, 32'h0000_2710,
    32'h0000_0014, 32'h0000_FFF9, 32'h0000_0000, 32'h0000_0000,
    32'h0000_03E8, 32'h0000_03E8, 32'h0000_0050, 32'h0000_1F40};

  // Verification modes.
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_NORM = 2'h1;
  localparam logic [1:0] MODE_EXT  = 2'h2;

  // Field positions and limits.
  localparam int          FAULT_POS_BIT = 12;
  localparam int          FAULT_CUR_BIT = 15;
  localparam int          CTRL_SRST_BIT = 0;
  localparam logic [31:0] SPP_MIN       = 32'h0000_0008;
  localparam logic [31:0] SPP_MAX       = 32'h0000_0400;
  localparam logic [31:0] PEAK_MAX_MA   = 32'h0000_4E20;
  localparam int          LOOP_SHIFT    = 16;

  typedef enum logic [1:0] {SLIP_IDLE, SLIP_NORMAL, SLIP_FAST} ssdc_slip_t;
endpackage : ssdc_pkg

// *** shared/ssdc_trap_if.sv ***
// Interface joining the controller to its current time trap timer.
`timescale 1ns/1ps
interface ssdc_trap_if;
  logic        tick;
  logic        over;
  logic [31:0] limit;
  logic        expired;
  modport timer (input tick, input over, input limit, output expired);
  modport owner (output over, output limit, input tick, input expired);
endinterface : ssdc_trap_if

// *** design/ssdc_tick_div.sv ***
// Divider producing a one-cycle enable pulse every DIV clocks.
`timescale 1ns/1ps
module ssdc_tick_div #(
  parameter int DIV = 1250
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);
  if (DIV < 2) begin : g_bad_div
    $error("ssdc_tick_div: DIV must be at least 2");
  end

  logic [31:0] cnt;

  // Free-running count; the pulse marks the first cycle of each period, while the count reads zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (cnt == 32'(DIV - 1)) begin
      cnt  <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule : ssdc_tick_div

// *** design/ssdc_trap_timer.sv ***
// Times how long the current stays over the trap level, in millisecond ticks.
`timescale 1ns/1ps
module ssdc_trap_timer (
  input wire logic  clk,
  input wire logic  rst_n,
  ssdc_trap_if.timer tb
);
  logic [31:0] ms;

  // Count saturates so a long overload never wraps back to a clean reading.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms <= 32'h0000_0000;
    end else if (!tb.over) begin
      ms <= 32'h0000_0000;
    end else if (tb.tick && ms != 32'hFFFF_FFFF) begin
      ms <= ms + 32'h0000_0001;
    end
  end

  // Expiry only once the time strictly exceeds the limit.
  assign tb.expired = tb.over && (ms > tb.limit);
endmodule : ssdc_trap_timer

// *** design/ssdc_drive_ctrl.sv ***
// Drive control for one axis: slip verification, stepper settings and servo loop.
// Behaviour
// - Verification mode 0 off, 1 normal, 2 extended.
// - At rest, compare command against encoder position.
// - Beyond tolerance, jog back at correction velocity.
// - Slip tolerance register, default 50 units.
// - Correction velocity register, default 4000 units/s.
// - Outer tolerance only matters in mode 2.
// - Mode 2 uses outer/inner hysteresis band.
// - After a move, mode 2 corrects fast.
// - At inner band, drop to normal velocity; the code ends the fast correction there instead.
// - Damping change applies after controller reset.
// - Over-level current too long sets fault bit 15.
// - Trap level register, default 2.0 A.
// - Integral hold zeroes integral gain during motion.
// - In-position when error within tolerance.
// - Loop current clamped to peak limit.
// - Proportional gain on velocity error, default 10000.
// - Integral gain on velocity error, default 20.
// - Fractional position gain, default 0.9999.
// - Acceleration feedforward only with velocity feedforward.
// - Steps per pole limited to 8..1024.
// - Holding current at rest, running current moving.
// - Velocity feedforward switch, default off.
// - Position error over maximum sets fault bit 12.
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module ssdc_drive_ctrl #(
  parameter int TRAP_TICK_DIV = ssdc_pkg::TRAP_TICK_CYCLES,
  parameter int LOOP_DIV      = ssdc_pkg::LOOP_CYCLES
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  input  wire logic               motion_active,
  input  wire logic               move_done,
  input  wire logic signed [31:0] cmd_pos,
  input  wire logic signed [31:0] enc_pos,
  input  wire logic signed [31:0] vel_err,
  input  wire logic signed [31:0] vel_cmd,
  input  wire logic signed [31:0] accel_cmd,
  output logic                    corr_active,
  output logic signed [31:0]      corr_velocity,
  output logic [15:0]             stepper_current_ma,
  output logic [10:0]             steps_per_pole,
  output logic                    damping_active,
  output logic signed [31:0]      servo_current_ma,
  output logic                    in_position,
  output logic                    fault_any
);
  import ssdc_pkg::*;

  if (TRAP_TICK_DIV < 2 || LOOP_DIV < 2) begin : g_bad_par
    $error("ssdc_drive_ctrl: divider counts must be at least 2");
  end

  logic [1:0]          rst_sync;
  logic                rst_n_i;
  logic [31:0]         cfg [NCFG];
  logic                wr_pend;
  logic [4:0]          wr_idx;
  logic                take;
  logic [31:0]         rd_val;
  logic [31:0]         fault;
  logic                soft_rst;
  logic                loop_tick;
  logic signed [32:0]  slip_diff;
  logic [32:0]         slip_mag;
  logic signed [32:0]  pos_err;
  logic [32:0]         pos_mag;
  logic                over_inner;
  logic                over_outer;
  ssdc_slip_t          slip_state;
  ssdc_slip_t          next_slip;
  logic signed [47:0]  integ;
  logic [31:0]         ki_eff;
  logic signed [63:0]  next_u;
  logic signed [63:0]  peak_s;
  logic [31:0]         cur_mag;
  ssdc_trap_if         trap_bus ();

  // Reset is released through two flops so every flop leaves reset on the same edge.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_i = rst_sync[1];

  // The slave never stalls and never errors.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign take      = hsel && hready && htrans[1];

  // Address phase capture; the write lands in the following data phase.
  always_ff @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend <= 1'b0;
      wr_idx  <= 5'h00;
    end else begin
      wr_pend <= take && hwrite && (haddr[31:7] == 25'h000_0000);
      wr_idx  <= haddr[6:2];
    end
  end

  // Read mux; unmapped words read as zero.
  always_comb begin
    rd_val = 32'h0000_0000;
    if (haddr[31:7] == 25'h000_0000) begin
      if (int'(haddr[6:2]) < NCFG) begin
        rd_val = cfg[haddr[6:2]];
      end else begin
        case (int'(haddr[6:2]))
          REG_FAULT:    rd_val = fault;
          REG_STATUS:   rd_val = {26'h000_0000, damping_active, in_position,
                                  corr_active, fault_any, 2'(slip_state)};
          REG_SLIPDIFF: rd_val = slip_diff[31:0];
          default:      rd_val = 32'h0000_0000;
        endcase
      end
    end
  end

  // Read data is registered at the address phase so it stands through the data phase.
  always_ff @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rd_val;
    end
  end

  // Configuration writes; out-of-range values are clamped, refused or cut to their low bits.
  always_ff @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NCFG; i++) begin
        cfg[i] <= CFG_RST[i];
      end
    end else if (wr_pend && int'(wr_idx) < NCFG) begin
      case (int'(wr_idx))
        REG_MODE: begin
          if (hwdata <= 32'(MODE_EXT)) begin
            cfg[wr_idx] <= hwdata;
          end
        end
        REG_DAMP, REG_IHOLD, REG_FFSW: begin
          cfg[wr_idx] <= {31'h0000_0000, hwdata[0]};
        end
        REG_SPP: begin
          if (hwdata < SPP_MIN) begin
            cfg[wr_idx] <= SPP_MIN;
          end else if (hwdata > SPP_MAX) begin
            cfg[wr_idx] <= SPP_MAX;
          end else begin
            cfg[wr_idx] <= hwdata;
          end
        end
        REG_PEAK: begin
          cfg[wr_idx] <= (hwdata > PEAK_MAX_MA) ? PEAK_MAX_MA : hwdata;
        end
        REG_KPOS: begin
          // Q16 keeps the gain below one; 65535 is the largest, about .99998.
          cfg[wr_idx] <= {16'h0000, hwdata[15:0]};
        end
        REG_RUN, REG_HOLD, REG_TLEVEL, REG_INPOS: begin
          cfg[wr_idx] <= {16'h0000, hwdata[15:0]};
        end
        default: begin
          cfg[wr_idx] <= hwdata;
        end
      endcase
    end
  end

  // A write of one to the control bit is the controller reset command.
  assign soft_rst = wr_pend && int'(wr_idx) == REG_CTRL && hwdata[CTRL_SRST_BIT];

  // Damping follows the register only at a controller reset, since the board
  // resynchronises its resonance filter only then.
  always_ff @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      damping_active <= 1'b0;
    end else if (soft_rst) begin
      damping_active <= cfg[REG_DAMP][0];
    end
  end

  // Slip and position error magnitudes, widened so no subtraction overflows.
  assign slip_diff  = 33'(cmd_pos) - 33'(enc_pos);
  assign slip_mag   = slip_diff[32] ? 33'(-slip_diff) : 33'(slip_diff);
  assign pos_err    = slip_diff;
  assign pos_mag    = slip_mag;
  assign over_inner = slip_mag > {1'b0, cfg[REG_INNER]};
  assign over_outer = slip_mag > {1'b0, cfg[REG_OUTER]};

  // Slip correction sequencing.
  always_comb begin
    next_slip = slip_state;
    case (slip_state)
      SLIP_IDLE: begin
        if (motion_active || cfg[REG_MODE][1:0] == MODE_OFF) begin
          next_slip = SLIP_IDLE;
        end else if (cfg[REG_MODE][1:0] == MODE_EXT) begin
          if (move_done && over_inner) begin
            next_slip = SLIP_FAST;
          end else if (over_outer) begin
            next_slip = SLIP_NORMAL;
          end
        end else if (over_inner) begin
          next_slip = SLIP_NORMAL;
        end
      end
      SLIP_NORMAL, SLIP_FAST: begin
        if (motion_active || cfg[REG_MODE][1:0] == MODE_OFF || !over_inner) begin
          next_slip = SLIP_IDLE;
        end
      end
      default: next_slip = SLIP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slip_state <= SLIP_IDLE;
    end else begin
      slip_state <= next_slip;
    end
  end

  // Correction velocity drives the motor toward the commanded position.
  always_ff @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      corr_active   <= 1'b0;
      corr_velocity <= 32'sh0000_0000;
    end else begin
      corr_active <= next_slip != SLIP_IDLE;
      if (next_slip == SLIP_IDLE) begin
        corr_velocity <= 32'sh0000_0000;
      end else begin
        corr_velocity <= slip_diff[32]
          ? -$signed(next_slip == SLIP_FAST ? cfg[REG_FVEL] : cfg[REG_NVEL])
          : $signed(next_slip == SLIP_FAST ? cfg[REG_FVEL] : cfg[REG_NVEL]);
      end
    end
  end

  // Stepper current and resolution outputs.
  always_ff @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stepper_current_ma <= 16'h0000;
      steps_per_pole     <= 11'h000;
    end else begin
      stepper_current_ma <= (motion_active || corr_active) ? cfg[REG_RUN][15:0]
                                                           : cfg[REG_HOLD][15:0];
      steps_per_pole     <= cfg[REG_SPP][10:0];
    end
  end

  ssdc_tick_div #(
    .DIV (LOOP_DIV)
  ) u_loop_div (
    .clk   (ref_clk),
    .rst_n (rst_n_i),
    .tick  (loop_tick)
  );

  // Velocity error integrator; a controller reset empties it.
  always_ff @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      integ <= 48'sh0000_0000_0000;
    end else if (soft_rst) begin
      integ <= 48'sh0000_0000_0000;
    end else if (loop_tick) begin
      integ <= integ + 48'(vel_err);
    end
  end

  // Integral gain is held at zero during motion to limit overshoot on heavy loads.
  assign ki_eff = (cfg[REG_IHOLD][0] && motion_active) ? 32'h0000_0000
                                                       : cfg[REG_KI];
  assign peak_s = $signed({32'h0000_0000, cfg[REG_PEAK]});

  // Loop sum: Q16 position term plus velocity, integral and feedforward terms.
  always_comb begin
    next_u = ((64'(pos_err) * $signed({48'h0000_0000_0000, cfg[REG_KPOS][15:0]}))
              >>> LOOP_SHIFT)
           + (((64'(vel_err) * $signed({32'h0000_0000, cfg[REG_KP]}))
              + (64'(integ) * $signed({32'h0000_0000, ki_eff}))
              + (cfg[REG_FFSW][0] ? 64'(vel_cmd)
                 + 64'(accel_cmd) * $signed({32'h0000_0000, cfg[REG_KF]})
                 : 64'sh0000_0000_0000_0000)) >>> LOOP_SHIFT);
    if (next_u > peak_s) begin
      next_u = peak_s;
    end else if (next_u < -peak_s) begin
      next_u = -peak_s;
    end
  end

  // Loop output and in-position flag update on the loop tick.
  always_ff @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      servo_current_ma <= 32'sh0000_0000;
      in_position      <= 1'b0;
    end else if (loop_tick) begin
      servo_current_ma <= next_u[31:0];
      in_position      <= pos_mag <= {1'b0, cfg[REG_INPOS]};
    end
  end

  assign cur_mag = servo_current_ma[31] ? 32'(-servo_current_ma) : 32'(servo_current_ma);

  // Millisecond tick and trap timer for the current time trap.
  ssdc_tick_div #(
    .DIV (TRAP_TICK_DIV)
  ) u_ms_div (
    .clk   (ref_clk),
    .rst_n (rst_n_i),
    .tick  (trap_bus.tick)
  );

  assign trap_bus.over  = cur_mag >= cfg[REG_TLEVEL];
  assign trap_bus.limit = cfg[REG_TTIME];

  ssdc_trap_timer u_trap (
    .clk   (ref_clk),
    .rst_n (rst_n_i),
    .tb    (trap_bus.timer)
  );

  // Sticky fault bits, write one to clear; a new trap in the clear cycle wins.
  always_ff @(posedge ref_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault <= 32'h0000_0000;
    end else begin
      if (wr_pend && int'(wr_idx) == REG_FAULT) begin
        fault[FAULT_POS_BIT] <= fault[FAULT_POS_BIT] & ~hwdata[FAULT_POS_BIT];
        fault[FAULT_CUR_BIT] <= fault[FAULT_CUR_BIT] & ~hwdata[FAULT_CUR_BIT];
      end
      if (pos_mag > {1'b0, cfg[REG_PEMAX]}) begin
        fault[FAULT_POS_BIT] <= 1'b1;
      end
      if (trap_bus.expired) begin
        fault[FAULT_CUR_BIT] <= 1'b1;
      end
    end
  end

  assign fault_any = fault[FAULT_POS_BIT] || fault[FAULT_CUR_BIT];
endmodule : ssdc_drive_ctrl

// *** verif/ssdc_drive_ctrl_asserts.sv ***
// Port-level assertions for the drive control block.
`timescale 1ns/1ps
module ssdc_drive_ctrl_asserts
  import ssdc_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               rst_n,
  input wire logic               hsel,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic               motion_active,
  input wire logic signed [31:0] cmd_pos,
  input wire logic signed [31:0] enc_pos,
  input wire logic               corr_active,
  input wire logic signed [31:0] corr_velocity,
  input wire logic [10:0]        steps_per_pole,
  input wire logic               damping_active,
  input wire logic signed [31:0] servo_current_ma,
  input wire logic               fault_any
);
  logic [3:0] up_cnt;
  wire        live     = up_cnt == 4'hF;
  wire        neg_slip = cmd_pos < enc_pos;
  wire        wr_req   = hsel && hwrite && htrans[1];

  // Edges since reset release; history from before reset must not trigger checks.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) up_cnt <= 4'h0;
    else if (!live) up_cnt <= up_cnt + 4'h1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus stall or error response");
  motion_idle_a: assert property (motion_active [*2] |-> !corr_active)
    else $error("correction while moving");
  corr_zero_a: assert property (!corr_active |-> corr_velocity == 32'sh0000_0000)
    else $error("idle with nonzero velocity");
  corr_dir_a: assert property (live && $rose(corr_active) |->
    corr_velocity != 32'sh0000_0000 && corr_velocity[31] == $past(neg_slip))
    else $error("correction in wrong direction");
  fault_clr_a: assert property (live && $fell(fault_any) |->
    $past(wr_req, 1) || $past(wr_req, 2) || $past(wr_req, 3))
    else $error("fault cleared without write");
  peak_lim_a: assert property (servo_current_ma <= $signed(PEAK_MAX_MA) &&
    servo_current_ma >= -$signed(PEAK_MAX_MA))
    else $error("current above ceiling");
  spp_range_a: assert property (live |-> steps_per_pole >= 11'(SPP_MIN) &&
    steps_per_pole <= 11'(SPP_MAX))
    else $error("resolution out of range");
  damp_cmd_a: assert property (live && $changed(damping_active) |->
    $past(wr_req, 2) || $past(wr_req, 3) || $past(wr_req, 4))
    else $error("damping changed without command");

  corr_c: cover property ($rose(corr_active));
  fault_c: cover property ($rose(fault_any));
  damp_c: cover property ($rose(damping_active));
endmodule : ssdc_drive_ctrl_asserts

// *** verif/ssdc_motor_model.sv ***
// Behavioural motor and encoder on the far side of the drive control block.
`timescale 1ns/1ps
module ssdc_motor_model #(
  parameter int STEP = 1
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               corr_active,
  input  wire logic signed [31:0] corr_velocity,
  output logic signed [31:0]      enc_pos
);
  // The shaft moves one step per cycle of an active jog, so slow convergence is exercised.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) enc_pos <= '0;
    else if (corr_active) enc_pos <= corr_velocity[31] ? enc_pos - STEP : enc_pos + STEP;
  end
endmodule : ssdc_motor_model

// *** verif/tb.sv ***
// Self-checking testbench for the drive control block.
`timescale 1ns/1ps
module tb;
  import ssdc_pkg::*;
  logic ref_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic motion_active, move_done, corr_active, damping_active, in_position, fault_any;
  logic signed [31:0] cmd_pos, enc_pos, vel_err, corr_velocity, servo_current_ma;
  logic signed [31:0] vel_cmd, accel_cmd;
  logic [15:0] stepper_current_ma;
  logic [10:0] steps_per_pole;
  int n_errors = 0;
  int n_checks = 0;
  assign hready = hreadyout;

  ssdc_drive_ctrl #(.TRAP_TICK_DIV(10), .LOOP_DIV(4)) dut_u (
    .ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hrdata, .hresp, .motion_active, .move_done, .cmd_pos, .enc_pos,
    .vel_err, .vel_cmd, .accel_cmd, .corr_active,
    .corr_velocity, .stepper_current_ma, .steps_per_pole, .damping_active,
    .servo_current_ma, .in_position, .fault_any);
  ssdc_motor_model mdl_u (.ref_clk, .rst_n, .corr_active, .corr_velocity, .enc_pos);

  // Free-running 125 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One single-word transfer; the wait is bounded, never assumed.
  task automatic bus(input logic wr, input int idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    @(posedge ref_clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= 32'(idx * 4);
    k = 0;
    do begin @(posedge ref_clk); k++; end while (hready !== 1'b1 && k < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do begin @(posedge ref_clk); k++; end while (hready !== 1'b1 && k < 50);
    rd = hrdata;
    if (k >= 50) begin n_errors++; tally_and_finish(); end
  endtask : bus

  task automatic wr(input int i, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, i, d, x);
  endtask : wr

  task automatic rd(input int i, output logic [31:0] d);
    bus(1'b0, i, 32'h0000_0000, d);
  endtask : rd

  // Waits for corr_active (sel 0) or fault_any (sel 1) to reach a level.
  task automatic wait_lvl(input int sel, input logic v, input int lim);
    int k;
    k = 0;
    while ((sel == 0 ? corr_active : fault_any) !== v && k < lim) begin
      @(posedge ref_clk); k++;
    end
    if (k >= lim) begin
      n_errors++;
      $display("CHECK FAILED wait %0d expected %b seen timeout", sel, v);
      tally_and_finish();
    end
  endtask : wait_lvl

  // Moving the command away from the shaft at rest creates a slip.
  task automatic slip(input logic signed [31:0] d);
    @(posedge ref_clk);
    cmd_pos <= enc_pos + d;
  endtask : slip

  task automatic t_reset;
    logic [31:0] d;
    for (int i = 0; i < NCFG; i++) begin
      rd(i, d);
      check("cfg reset", d, CFG_RST[i]);
    end
    rd(REG_FAULT, d);
    check("fault reset", d, 32'h0000_0000);
    rd(NREG, d);
    check("unmapped", d, 32'h0000_0000);
    check("spp port", steps_per_pole, 32'h0000_0050);
    check("hold port", stepper_current_ma, CFG_RST[REG_HOLD]);
  endtask : t_reset

  task automatic t_limits;
    int idx[4] = '{REG_MODE, REG_SPP, REG_SPP, REG_PEAK};
    logic [31:0] wv[4] = '{32'h0000_0003, 32'h0000_0004, 32'h0000_07D0, 32'h0000_7530};
    logic [31:0] ev[4] = '{MODE_OFF, SPP_MIN, SPP_MAX, PEAK_MAX_MA};
    logic [31:0] d;
    for (int i = 0; i < 4; i++) begin
      wr(idx[i], wv[i]);
      rd(idx[i], d);
      check("limited", d, ev[i]);
    end
    check("spp port", steps_per_pole, SPP_MAX);
  endtask : t_limits

  task automatic t_slip_norm;
    wr(REG_INNER, 32'h0000_0005);
    wr(REG_OUTER, 32'h0000_0064);
    slip(32'sh0000_0014);
    repeat (20) @(posedge ref_clk);
    check("mode off", corr_active, 32'h0000_0000);
    wr(REG_MODE, MODE_NORM);
    wait_lvl(0, 1'b1, 20);
    check("norm vel", corr_velocity, CFG_RST[REG_NVEL]);
    wait_lvl(0, 1'b0, 100);
    check("in band", 32'(cmd_pos - enc_pos <= 5), 32'h0000_0001);
    check("idle vel", corr_velocity, 32'h0000_0000);
  endtask : t_slip_norm

  task automatic t_slip_ext;
    wr(REG_OUTER, 32'h0000_001E);
    wr(REG_FVEL, 32'h0000_1F40);
    wr(REG_MODE, MODE_EXT);
    slip(-32'sh0000_0014);
    repeat (20) @(posedge ref_clk);
    check("inside outer", corr_active, 32'h0000_0000);
    @(posedge ref_clk) move_done <= 1'b1;
    @(posedge ref_clk) move_done <= 1'b0;
    wait_lvl(0, 1'b1, 10);
    check("fast vel", corr_velocity, -32'h0000_1F40);
    wait_lvl(0, 1'b0, 100);
    check("inner band", 32'(enc_pos - cmd_pos <= 5), 32'h0000_0001);
    slip(-32'sh0000_0028);
    wait_lvl(0, 1'b1, 10);
    check("outer vel", corr_velocity, -CFG_RST[REG_NVEL]);
    wait_lvl(0, 1'b0, 100);
    wr(REG_MODE, MODE_OFF);
  endtask : t_slip_ext

  task automatic t_misc;
    logic [31:0] d;
    wr(REG_RUN, 32'h0000_05DC);
    wr(REG_HOLD, 32'h0000_02BC);
    @(posedge ref_clk) motion_active <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("run cur", stepper_current_ma, 32'h0000_05DC);
    motion_active <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check("hold cur", stepper_current_ma, 32'h0000_02BC);
    wr(REG_DAMP, 32'h0000_0001);
    repeat (3) @(posedge ref_clk);
    check("damp wait", damping_active, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0001);
    repeat (3) @(posedge ref_clk);
    check("damp on", damping_active, 32'h0000_0001);
    wr(REG_PEMAX, 32'h0000_000A);
    slip(32'sh0000_0032);
    wait_lvl(1, 1'b1, 20);
    slip(32'sh0000_0000);
    repeat (5) @(posedge ref_clk);
    rd(REG_FAULT, d);
    check("pos trap", d, 32'h0000_1000);
    wr(REG_FAULT, 32'h0000_1000);
    rd(REG_FAULT, d);
    check("trap clear", d, 32'h0000_0000);
  endtask : t_misc

  task automatic t_ff;
    vel_cmd <= 32'sh0003_0000;
    accel_cmd <= 32'sh0001_0000;
    wr(REG_KF, 32'h0000_0002);
    repeat (6) @(posedge ref_clk);
    check("ff off", servo_current_ma, 32'h0000_0000);
    wr(REG_FFSW, 32'h0000_0001);
    repeat (6) @(posedge ref_clk);
    check("ff on", servo_current_ma, 32'h0000_0005);
    wr(REG_FFSW, 32'h0000_0000);
    wr(REG_KP, 32'h0000_0000);
    wr(REG_IHOLD, 32'h0000_0001);
    motion_active <= 1'b1;
    vel_err <= 32'sh0001_0000;
    repeat (12) @(posedge ref_clk);
    check("i held", servo_current_ma, 32'h0000_0000);
    motion_active <= 1'b0;
    vel_err <= 32'sh0000_0000;
    repeat (6) @(posedge ref_clk);
    check("i back", 32'(servo_current_ma > 0), 32'h0000_0001);
    wr(REG_KP, CFG_RST[REG_KP]);
  endtask : t_ff

  task automatic t_cur_trap;
    logic [31:0] d;
    wr(REG_PEAK, 32'h0000_0064);
    wr(REG_TLEVEL, 32'h0000_0032);
    wr(REG_TTIME, 32'h0000_0002);
    @(posedge ref_clk) vel_err <= 32'sh0001_86A0;
    repeat (12) @(posedge ref_clk);
    check("clamped", servo_current_ma, 32'h0000_0064);
    check("in pos", in_position, 32'h0000_0001);
    check("trap early", fault_any, 32'h0000_0000);
    wait_lvl(1, 1'b1, 200);
    rd(REG_FAULT, d);
    check("cur trap", d, 32'h0000_8000);
  endtask : t_cur_trap

  // Reset for four cycles, then each scenario in turn.
  initial begin
    rst_n = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = '0; motion_active = 1'b0; move_done = 1'b0;
    cmd_pos = '0; vel_err = '0; vel_cmd = '0; accel_cmd = '0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_limits();
    t_slip_norm();
    t_slip_ext();
    t_misc();
    t_ff();
    t_cur_trap();
    tally_and_finish();
  end
endmodule : tb

bind ssdc_drive_ctrl ssdc_drive_ctrl_asserts chk_u (
  .ref_clk, .rst_n, .hsel, .htrans, .hwrite, .hreadyout, .hresp, .motion_active,
  .cmd_pos, .enc_pos, .corr_active, .corr_velocity, .steps_per_pole,
  .damping_active, .servo_current_ma, .fault_any);
